// *** design/scf_spi_ctrl.sv ***
// serial port clock generation, frame pulse and word engine behind an apb slave
`default_nettype none
`include "scf_defs.svh"

module scf_spi_ctrl #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_serial_clock_pin,
    output logic o_serial_clock_pin_oe,
    output logic o_serial_out_pin,
    output logic o_serial_out_pin_oe,
    input wire logic i_serial_in_pin,
    input wire logic i_frame_pulse,
    output logic o_frame_pulse,
    output logic o_frame_pulse_oe
);
    localparam int AW = $clog2(FIFO_DEPTH);

    // pointers wrap by overflow, so only powers of two are served
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("FIFO_DEPTH must be a power of two, at least 2");
    end

    logic [15:0] con1_q;
    logic [15:0] con2_q;
    logic ena_q;
    logic ovf_q;
    logic [15:0] txm_q [FIFO_DEPTH];
    logic [15:0] rxm_q [FIFO_DEPTH];
    logic [AW-1:0] txw_q, txr_q, rxw_q, rxr_q;
    logic [AW:0] txn_q, rxn_q;
    scf_pkg::scf_state_t st_q;
    logic [9:0] cnt_q;
    logic [4:0] bit_q;
    logic [15:0] sh_q;
    logic samp_q;

    // apb decode; every access completes in its first access cycle, with no wait state
    logic acc, wr, rd, hit;
    assign acc = i_psel & i_penable & o_pready;
    assign wr = acc & i_pwrite;
    assign rd = acc & ~i_pwrite;
    assign hit = i_paddr == `SCF_OFF_CON1 || i_paddr == `SCF_OFF_CON2
        || i_paddr == `SCF_OFF_ENA || i_paddr == `SCF_OFF_DATA
        || i_paddr == `SCF_OFF_STAT;

    // decoded control fields
    logic w16, sphase, cke, ckp, mst, frm, fdir, fpol, fedge, ben;
    assign w16 = con1_q[`SCF_C1_W16];
    assign sphase = con1_q[`SCF_C1_SPHASE];
    assign ckp = con1_q[`SCF_C1_CKP];
    assign mst = con1_q[`SCF_C1_MST];
    assign frm = con2_q[`SCF_C2_FRM];
    assign fdir = con2_q[`SCF_C2_FDIR];
    assign fpol = con2_q[`SCF_C2_FPOL];
    assign fedge = con2_q[`SCF_C2_FEDGE];
    assign ben = con2_q[`SCF_C2_BUF];
    assign cke = con1_q[`SCF_C1_CKE] & ~frm;

    // bit period; a product of 1 is not a usable rate, so it runs at 2
    logic [9:0] prod, div, half;
    assign prod = 10'(scf_pkg::scf_prim_div(con1_q[1:0])
        * scf_pkg::scf_sec_div(con1_q[4:2]));
    assign div = (prod < 10'h002) ? 10'h002 : prod;
    assign half = div >> 1;

    // buffer capacity follows the buffer enable
    logic [AW:0] cap;
    assign cap = ben ? (AW+1)'(FIFO_DEPTH) : (AW+1)'(1);

    logic push_tx, pop_rx, start, bit_end, last, push_rx, fin_ok;
    assign push_tx = wr && i_paddr == `SCF_OFF_DATA && txn_q < cap;
    assign pop_rx = rd && i_paddr == `SCF_OFF_DATA && rxn_q != '0;
    assign bit_end = cnt_q == div - 10'h001;
    assign last = bit_q == (w16 ? 5'h0F : 5'h07);
    assign push_rx = st_q == scf_pkg::scf_shift && bit_end && last;
    assign fin_ok = rxn_q < cap;

    // a sample on the bit's last cycle must reach the shift at once
    logic [9:0] samp_at;
    logic bit_in;
    assign samp_at = sphase ? div - 10'h001 : half;
    assign bit_in = (cnt_q == samp_at) ? i_serial_in_pin : samp_q;
    assign start = ena_q && mst && st_q == scf_pkg::scf_idle && txn_q != '0
        && !(frm && fdir && (i_frame_pulse != fpol));

    // apb handshake and read data
    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
        end
        else
        begin
            o_pready <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & ~hit;
            o_prdata <= 32'h0000_0000;
            if (i_psel && !i_penable)
            begin
                unique case (i_paddr)
                    `SCF_OFF_CON1: o_prdata <= {16'h0000, con1_q};
                    `SCF_OFF_CON2: o_prdata <= {16'h0000, con2_q};
                    `SCF_OFF_ENA: o_prdata <= {31'h0000_0000, ena_q};
                    `SCF_OFF_DATA: o_prdata <= {16'h0000, rxm_q[rxr_q]};
                    `SCF_OFF_STAT: o_prdata <= {26'h000_0000, st_q != scf_pkg::scf_idle,
                        ovf_q, rxn_q == '0, txn_q == '0, rxn_q == cap, txn_q == cap};
                    default: o_prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // control registers; reserved bits are held at zero
    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            con1_q <= `SCF_CON1_RST;
            con2_q <= `SCF_CON2_RST;
            ena_q <= 1'b0;
        end
        else if (wr)
        begin
            if (i_paddr == `SCF_OFF_CON1)
                con1_q <= i_pwdata[15:0] & `SCF_C1_MASK;
            if (i_paddr == `SCF_OFF_CON2)
                con2_q <= i_pwdata[15:0] & `SCF_C2_MASK;
            if (i_paddr == `SCF_OFF_ENA)
                ena_q <= i_pwdata[0];
        end
    end

    // overflow: a lost word sets it, write one clears; set wins
    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
            ovf_q <= 1'b0;
        else if (push_rx && !fin_ok)
            ovf_q <= 1'b1;
        else if (wr && i_paddr == `SCF_OFF_STAT && i_pwdata[`SCF_ST_OVF])
            ovf_q <= 1'b0;
    end

    // transmit buffer; a write while full is dropped
    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            txw_q <= '0;
            txr_q <= '0;
            txn_q <= '0;
        end
        else
        begin
            if (push_tx)
            begin
                txm_q[txw_q] <= i_pwdata[15:0];
                txw_q <= txw_q + 1'b1;
            end
            if (start)
                txr_q <= txr_q + 1'b1;
            txn_q <= txn_q + (AW+1)'(push_tx) - (AW+1)'(start);
        end
    end

    // receive buffer; a word arriving while full is lost
    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            rxw_q <= '0;
            rxr_q <= '0;
            rxn_q <= '0;
        end
        else
        begin
            if (push_rx && fin_ok)
            begin
                rxm_q[rxw_q] <= w16 ? {sh_q[14:0], bit_in} : {8'h00, sh_q[6:0], bit_in};
                rxw_q <= rxw_q + 1'b1;
            end
            if (pop_rx)
                rxr_q <= rxr_q + 1'b1;
            rxn_q <= rxn_q + (AW+1)'(push_rx && fin_ok) - (AW+1)'(pop_rx);
        end
    end

    // word engine: optional lead-in frame slot, then one bit per period
    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            st_q <= scf_pkg::scf_idle;
            cnt_q <= 10'h000;
            bit_q <= 5'h00;
            sh_q <= 16'h0000;
            samp_q <= 1'b0;
        end
        else
        begin
            cnt_q <= (st_q == scf_pkg::scf_idle || bit_end) ? 10'h000 : cnt_q + 10'h001;
            unique case (st_q)
                scf_pkg::scf_idle:
                begin
                    bit_q <= 5'h00;
                    if (start)
                    begin
                        sh_q <= txm_q[txr_q];
                        st_q <= (frm && !fdir && !fedge) ? scf_pkg::scf_frame
                            : scf_pkg::scf_shift;
                    end
                end
                scf_pkg::scf_frame:
                    if (bit_end)
                        st_q <= scf_pkg::scf_shift;
                scf_pkg::scf_shift:
                begin
                    if (cnt_q == samp_at)
                        samp_q <= i_serial_in_pin;
                    if (bit_end)
                    begin
                        sh_q <= {sh_q[14:0], bit_in};
                        bit_q <= bit_q + 5'h01;
                        if (last)
                            st_q <= scf_pkg::scf_idle;
                    end
                end
                default: st_q <= scf_pkg::scf_idle;
            endcase
        end
    end

    // active half of the clock and the frame pulse window
    logic act, fp_act;
    assign act = cke ? (cnt_q >= half) : (cnt_q < half);
    assign fp_act = (st_q == scf_pkg::scf_frame)
        || (st_q == scf_pkg::scf_shift && bit_q == 5'h00 && fedge);

    // pin drivers, registered; clock and data out enables follow the pin disables
    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            o_serial_clock_pin <= 1'b0;
            o_serial_clock_pin_oe <= 1'b0;
            o_serial_out_pin <= 1'b0;
            o_serial_out_pin_oe <= 1'b0;
            o_frame_pulse <= 1'b1; // inactive for the default low polarity
            o_frame_pulse_oe <= 1'b0;
        end
        else
        begin
            o_serial_clock_pin <= ckp ^ (st_q == scf_pkg::scf_shift && act);
            o_serial_clock_pin_oe <= ena_q & mst & ~con1_q[`SCF_C1_CLKDIS];
            o_serial_out_pin <= w16 ? sh_q[15] : sh_q[7];
            o_serial_out_pin_oe <= ena_q & ~con1_q[`SCF_C1_OUTDIS];
            o_frame_pulse <= ~fpol ^ (frm && !fdir && fp_act);
            o_frame_pulse_oe <= ena_q & frm & ~fdir;
        end
    end

    // checks
    a_div_product : assert property (@(posedge i_clock) disable iff (!i_reset_n)
        con1_q[4:0] == 5'h1A |-> div == 10'h008)
        else $error("primary 4 by secondary 2 must give 8");
    a_prim_slow : assert property (@(posedge i_clock) disable iff (!i_reset_n)
        con1_q[4:0] == 5'h00 |-> div == 10'h200)
        else $error("slowest setting must divide by 512");
    a_bit_period : assert property (@(posedge i_clock) disable iff (!i_reset_n)
        st_q != scf_pkg::scf_idle && $stable(con1_q)
        |-> cnt_q < div)
        else $error("bit counter ran past its period");
    a_cke_framed : assert property (@(posedge i_clock) disable iff (!i_reset_n)
        frm && st_q == scf_pkg::scf_shift && cnt_q < half
        |=> o_serial_clock_pin != $past(ckp))
        else $error("edge select used in framed mode");
    a_frame_lead : assert property (@(posedge i_clock) disable iff (!i_reset_n)
        start && frm && !fdir && !fedge |=> st_q == scf_pkg::scf_frame)
        else $error("frame pulse did not precede first bit");
    a_buf_legacy : assert property (@(posedge i_clock) disable iff (!i_reset_n)
        !ben && $stable(ben) |-> txn_q <= (AW+1)'(1) || $past(ben))
        else $error("legacy mode held more than one word");
    a_word_len : assert property (@(posedge i_clock) disable iff (!i_reset_n)
        st_q == scf_pkg::scf_shift |-> bit_q <= (w16 ? 5'h0F : 5'h07))
        else $error("bit count beyond word");
    a_frame_dir : assert property (@(posedge i_clock) disable iff (!i_reset_n)
        frm && fdir |=> !o_frame_pulse_oe)
        else $error("frame slave drove the frame pulse");
    c_framed : cover property (@(posedge i_clock) disable iff (!i_reset_n)
        st_q == scf_pkg::scf_frame ##1 st_q == scf_pkg::scf_shift);
    c_word16 : cover property (@(posedge i_clock) disable iff (!i_reset_n)
        push_rx && w16);
    c_overflow : cover property (@(posedge i_clock) disable iff (!i_reset_n)
        push_rx && !fin_ok);
endmodule : scf_spi_ctrl
`default_nettype wire

// *** inc/scf_defs.svh ***
// register map, field positions and reset values of the serial clock and frame control
`ifndef SCF_DEFS_SVH
`define SCF_DEFS_SVH
`define SCF_OFF_CON1 12'h000
`define SCF_OFF_CON2 12'h004
`define SCF_OFF_ENA 12'h008
`define SCF_OFF_DATA 12'h00C
`define SCF_OFF_STAT 12'h010
`define SCF_CON1_RST 16'h0000
`define SCF_CON2_RST 16'h0000
`define SCF_C1_CLKDIS 12
`define SCF_C1_OUTDIS 11
`define SCF_C1_W16 10
`define SCF_C1_SPHASE 9
`define SCF_C1_CKE 8
`define SCF_C1_SSELEN 7
`define SCF_C1_CKP 6
`define SCF_C1_MST 5
`define SCF_C2_FRM 15
`define SCF_C2_FDIR 14
`define SCF_C2_FPOL 13
`define SCF_C2_FEDGE 1
`define SCF_C2_BUF 0
`define SCF_C1_MASK 16'h1FFF
`define SCF_C2_MASK 16'hE003
`define SCF_ST_OVF 4
`endif

// *** inc/scf_pkg.sv ***
// types and divider decode of the serial clock and frame control
`default_nettype none
package scf_pkg;
    typedef enum logic [1:0]
    {
        scf_idle = 2'b00,
        scf_frame = 2'b01,
        scf_shift = 2'b10
    } scf_state_t;

    // primary factor: 11->1, 10->4, 01->16, 00->64
    function automatic logic [9:0] scf_prim_div(input logic [1:0] code);
        scf_prim_div = 10'h001 << {code ^ 2'b11, 1'b0};
    endfunction : scf_prim_div

    // secondary factor: 111->1 down to 000->8
    function automatic logic [9:0] scf_sec_div(input logic [2:0] code);
        scf_sec_div = {6'h00, 4'h8 - {1'b0, code}};
    endfunction : scf_sec_div
endpackage : scf_pkg
`default_nettype wire

// *** testbench/scf_echo_peer.sv ***
// echo device standing on the far side of the serial link
`default_nettype none
module scf_echo_peer (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_sdo,
    input wire logic i_sdo_oe,
    output logic o_sdi
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_q;
    // remember the last level so a released line never repeats it
    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
            last_q <= 1'b0;
        else
            last_q <= o_sdi;
    end
    // echo what the port shifts out; undriven line toggles every cycle
    assign o_sdi = i_sdo_oe ? i_sdo : ~last_q;
endmodule : scf_echo_peer
`default_nettype wire

// *** testbench/scf_spi_ctrl_tb.sv ***
// self-checking bench of the serial clock and frame control
`default_nettype none
`include "scf_defs.svh"
module scf_spi_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic fp_in = 1'b0;
    logic [31:0] prdata, q;
    logic pready, pslverr, sck, sck_oe, sdo, sdo_oe, sdi, fp_out, fp_oe, e;
    logic sck_d = 1'b0, fp_d = 1'b1, armed = 1'b0;
    int fail_count = 0, n_tests = 0, n, b;
    int cyc = 0, edges = 0, period = 0, lr = 0, fp_t = 0, gap = -1;
    always #10 i_clock = ~i_clock;
    scf_spi_ctrl #(.FIFO_DEPTH(4)) uut (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_serial_clock_pin(sck), .o_serial_clock_pin_oe(sck_oe),
        .o_serial_out_pin(sdo), .o_serial_out_pin_oe(sdo_oe), .i_serial_in_pin(sdi),
        .i_frame_pulse(fp_in), .o_frame_pulse(fp_out), .o_frame_pulse_oe(fp_oe));
    scf_echo_peer peer (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_sdo(sdo),
        .i_sdo_oe(sdo_oe), .o_sdi(sdi));
    // clock rise spacing, and distance from frame pulse to first clock rise
    always @(posedge i_clock)
    begin
        cyc <= cyc + 1;
        sck_d <= sck;
        fp_d <= fp_out;
        if (fp_out && !fp_d)
        begin
            fp_t <= cyc;
            armed <= 1'b1;
        end
        if (sck && !sck_d)
        begin
            edges <= edges + 1;
            period <= cyc - lr;
            lr <= cyc;
            if (armed || (fp_out && !fp_d))
                gap <= armed ? cyc - fp_t : 0;
            armed <= 1'b0;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one apb transfer; request held until ready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        do
        begin
            @(posedge i_clock);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        chk(k < 20, 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // poll one status bit, bounded
    task automatic wait_st(input int bit_no, input logic v);
        int k;
        k = 0;
        do
        begin
            apb(1'b0, `SCF_OFF_STAT, 32'h0000_0000);
            k++;
        end
        while (q[bit_no] !== v && k < 3000);
        chk(q[bit_no], v);
    endtask : wait_st
    task automatic cfg(input logic [15:0] c1, input logic [15:0] c2);
        apb(1'b1, `SCF_OFF_CON1, {16'h0000, c1});
        apb(1'b1, `SCF_OFF_CON2, {16'h0000, c2});
        apb(1'b1, `SCF_OFF_ENA, 32'h0000_0001);
    endtask : cfg
    // send one word, echo returns it; check data and clock count
    task automatic xfer(input logic [15:0] d, input int bits);
        int b0;
        b0 = edges;
        apb(1'b1, `SCF_OFF_DATA, {16'h0000, d});
        wait_st(3, 1'b0);
        apb(1'b0, `SCF_OFF_DATA, 32'h0000_0000);
        chk(q, (bits == 16) ? {16'h0000, d} : {24'h00_0000, d[7:0]});
        chk(edges - b0, bits);
    endtask : xfer
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    // watchdog well past the expected run of about 26k cycles
    initial
    begin
        #1600000;
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        end_sim();
    end
    initial
    begin
        repeat (10) @(posedge i_clock);
        i_reset_n <= 1'b1;
        apb(1'b0, `SCF_OFF_CON2, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        apb(1'b0, `SCF_OFF_STAT, 32'h0000_0000);
        chk(q, 32'h0000_000C);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk({e, q}, {1'b1, 32'h0000_0000});
        apb(1'b1, `SCF_OFF_CON2, 32'hFFFF_FFFF);
        apb(1'b0, `SCF_OFF_CON2, 32'h0000_0000);
        chk(q, 32'h0000_E003);
        $display("test registers done");
        // every divider pair; sample phase alternates with the code
        for (int p = 0; p < 4; p++)
            for (int s = 0; s < 8; s++)
            begin
                n = (1 << (2 * (3 - p))) * (8 - s);
                cfg(16'h0020 | 16'(s << 2) | 16'(p) | 16'((s & 1) << 9), 16'h0000);
                xfer(16'(8'h5A ^ 8'(p * 8 + s)), 8);
                chk(period, (n == 1) ? 2 : n);
            end
        cfg(16'h0633, 16'h0000);
        xfer(16'hA5C3, 16);
        $display("test dividers and width done");
        // framed master; second pass leaves edge select set, it must be ignored
        for (int f = 0; f < 2; f++)
        begin
            cfg(16'h0033 | 16'(f << 8), 16'hA000 | 16'(f << 1));
            xfer(16'h0096, 8);
            chk(fp_oe, 1'b1);
            chk(gap, f ? 0 : 4);
        end
        cfg(16'h0033, 16'hE000);
        b = edges;
        apb(1'b1, `SCF_OFF_DATA, 32'h0000_003C);
        repeat (40) @(posedge i_clock);
        chk(edges - b, 0);
        chk(fp_oe, 1'b0);
        fp_in <= 1'b1;
        wait_st(3, 1'b0);
        fp_in <= 1'b0;
        apb(1'b0, `SCF_OFF_DATA, 32'h0000_0000);
        chk(q, 32'h0000_003C);
        $display("test frames done");
        // legacy buffer holds one word, enhanced holds four
        apb(1'b1, `SCF_OFF_ENA, 32'h0000_0000);
        apb(1'b1, `SCF_OFF_CON2, 32'h0000_0000);
        apb(1'b1, `SCF_OFF_DATA, 32'h0000_0011);
        wait_st(0, 1'b1);
        chk(q[0], 1'b1);
        apb(1'b1, `SCF_OFF_ENA, 32'h0000_0001);
        wait_st(3, 1'b0);
        // a second word with the single entry still unread is lost
        apb(1'b1, `SCF_OFF_DATA, 32'h0000_0012);
        wait_st(4, 1'b1);
        apb(1'b1, `SCF_OFF_STAT, 32'h0000_0010);
        apb(1'b0, `SCF_OFF_STAT, 32'h0000_0000);
        chk(q[4], 1'b0);
        apb(1'b0, `SCF_OFF_DATA, 32'h0000_0000);
        chk(q, 32'h0000_0011);
        apb(1'b1, `SCF_OFF_ENA, 32'h0000_0000);
        apb(1'b1, `SCF_OFF_CON2, 32'h0000_0001);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, `SCF_OFF_DATA, 32'h0000_0020 + i);
            apb(1'b0, `SCF_OFF_STAT, 32'h0000_0000);
            chk(q[0], i == 3);
        end
        apb(1'b1, `SCF_OFF_ENA, 32'h0000_0001);
        wait_st(1, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, `SCF_OFF_DATA, 32'h0000_0000);
            chk(q, 32'h0000_0020 + i);
        end
        $display("test buffers done");
        cfg(16'h1033, 16'h0000);
        repeat (2) @(posedge i_clock);
        chk({sck_oe, sdo_oe}, 2'b01);
        cfg(16'h0833, 16'h0000);
        repeat (2) @(posedge i_clock);
        chk({sck_oe, sdo_oe}, 2'b10);
        $display("test pin enables done");
        end_sim();
    end
endmodule : scf_spi_ctrl_tb
`default_nettype wire
